/* core/ppm_consts.vh */
`ifndef PPM_CONSTS_VH
`define PPM_CONSTS_VH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define PPM_IDX_PORT1_CTRL   8'h1D
`define PPM_IDX_PORT2_CTRL   8'h2D
`define PPM_IDX_POWER_MODE   8'hC3
`define PPM_IDX_SLEEP_DELAY  8'hC4
`define PPM_IDX_POWER_STATUS 8'hC8

// ****************************************************************
// Field positions.
// ****************************************************************
`define PPM_PORT_PD_BIT      3
`define PPM_MODE_LSB         0
`define PPM_MODE_MSB         1
`define PPM_PLL_OFF_BIT      2

// ****************************************************************
// Mode codes.
// ****************************************************************
`define PPM_MODE_NORMAL      2'h0
`define PPM_MODE_ENERGY      2'h1
`define PPM_MODE_SOFT_PD     2'h2
`define PPM_MODE_PSAVE       2'h3

// ****************************************************************
// Reset values.
// ****************************************************************
`define PPM_RST_PORT_CTRL    8'h00
`define PPM_RST_POWER_MODE   8'h00
`define PPM_RST_SLEEP_DELAY  8'h50

// ****************************************************************
// Timing: clock period, link pulse, pulse period and go-sleep unit.
// ****************************************************************
`define PPM_CLK_PERIOD_NS    4
`define PPM_PULSE_WIDTH_NS   120
`define PPM_PULSE_WIDTH_CYC  ((`PPM_PULSE_WIDTH_NS + `PPM_CLK_PERIOD_NS - 1) / `PPM_CLK_PERIOD_NS)
`define PPM_PULSE_PERIOD_NS  1000000000
`define PPM_PULSE_PERIOD_CYC (`PPM_PULSE_PERIOD_NS / `PPM_CLK_PERIOD_NS)
`define PPM_SLEEP_UNIT_NS    1000000
`define PPM_SLEEP_UNIT_CYC   (`PPM_SLEEP_UNIT_NS / `PPM_CLK_PERIOD_NS)

`endif

/* core/ppm_pulse_timer.v */
`timescale 1ns/100ps
`include "ppm_consts.vh"

module ppm_pulse_timer
#(
  parameter PERIOD_CYC = `PPM_PULSE_PERIOD_CYC,
  parameter WIDTH_CYC  = `PPM_PULSE_WIDTH_CYC,
  parameter UNIT_CYC   = `PPM_SLEEP_UNIT_CYC
)
(
  input  wire ref_clk,
  input  wire sys_rst,
  input  wire pulse_run,
  output reg  link_pulse,
  output reg  unit_tick
);

  reg [31:0] period_cnt;
  reg [31:0] unit_cnt;

  // ****************************************************************
  // Link pulse generator.
  // ****************************************************************
  // The pulse starts at the first count of each period so that a new
  // run begins with a pulse rather than a one second silence.
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      period_cnt <= 32'h00000000;
      link_pulse <= 1'b0;
    end
    else if (!pulse_run)
    begin
      // A pulse under way is finished, since a cut pulse would reach the
      // partner shorter than the fixed pulse width.
      if (link_pulse)
      begin
        period_cnt <= period_cnt + 32'h00000001;
        link_pulse <= (period_cnt < WIDTH_CYC);
      end
      else
      begin
        period_cnt <= 32'h00000000;
        link_pulse <= 1'b0;
      end
    end
    else
    begin
      if (period_cnt >= PERIOD_CYC - 1)
        period_cnt <= 32'h00000000;
      else
        period_cnt <= period_cnt + 32'h00000001;
      link_pulse <= (period_cnt < WIDTH_CYC);
    end
  end

  // ****************************************************************
  // Go-sleep time base.
  // ****************************************************************
  // A free running tick; the sleep counter counts these units.
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      unit_cnt  <= 32'h00000000;
      unit_tick <= 1'b0;
    end
    else
    begin
      unit_tick <= (unit_cnt >= UNIT_CYC - 1);
      if (unit_cnt >= UNIT_CYC - 1)
        unit_cnt <= 32'h00000000;
      else
        unit_cnt <= unit_cnt + 32'h00000001;
    end
  end

endmodule // ppm_pulse_timer

/* core/ppm_power_ctrl.v */
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "ppm_consts.vh"

module ppm_power_ctrl
#(
  parameter PULSE_PERIOD_CYC = `PPM_PULSE_PERIOD_CYC,
  parameter SLEEP_UNIT_CYC   = `PPM_SLEEP_UNIT_CYC
)
(
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        autoneg_en,
  input  wire        cable_present,
  input  wire        cable_energy,
  input  wire        link_up,
  output reg         pll_clk_en,
  output reg         mac_en,
  output reg         host_if_en,
  output reg  [1:0]  phy_tx_en,
  output reg  [1:0]  phy_rx_en,
  output reg  [1:0]  phy_rx_unused_off,
  output reg         energy_det_en,
  output wire        link_pulse
);

  // ****************************************************************
  // Power states.
  // ****************************************************************
  localparam [2:0] ST_NORMAL  = 3'h0;
  localparam [2:0] ST_PSAVE   = 3'h1;
  localparam [2:0] ST_ED_ON   = 3'h2;
  localparam [2:0] ST_ED_LOW  = 3'h3;
  localparam [2:0] ST_SOFT_PD = 3'h4;

  reg  [7:0]  port1_phy_control;
  reg  [7:0]  port2_phy_control;
  reg  [7:0]  power_mode_control;
  reg  [7:0]  sleep_delay_time;
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [8:0]  idle_units;
  reg  [31:0] next_prdata;
  reg         next_pll_clk_en;
  reg         next_mac_en;
  reg         next_host_if_en;
  reg  [1:0]  next_phy_tx_en;
  reg  [1:0]  next_phy_rx_en;
  reg  [1:0]  next_rx_unused_off;
  reg         next_energy_det_en;
  wire        unit_tick;
  wire        pulse_run;
  wire        wr_take;
  wire        wr_blocked;
  wire        aligned;
  wire [7:0]  reg_idx;
  wire [1:0]  mode;
  wire        pll_off;
  wire [1:0]  port_pd;

  assign mode    = power_mode_control[`PPM_MODE_MSB:`PPM_MODE_LSB];
  assign pll_off = power_mode_control[`PPM_PLL_OFF_BIT];
  assign port_pd = {port2_phy_control[`PPM_PORT_PD_BIT], port1_phy_control[`PPM_PORT_PD_BIT]};

  // ****************************************************************
  // APB slave.
  // ****************************************************************
  // Zero wait states: read data is captured in the setup cycle so it
  // comes from a flip-flop yet is valid in the first access cycle.
  assign pready  = 1'b1;
  assign aligned = (paddr[1:0] == 2'h0);
  assign reg_idx = paddr[9:2];

  // The host interface is off in the low-power and soft power-down
  // states; only a mode write may still land in soft power down so
  // that software can wake the device.
  assign wr_blocked = (state == ST_ED_LOW) ||
                      ((state == ST_SOFT_PD) && (reg_idx != `PPM_IDX_POWER_MODE));
  assign wr_take    = psel && penable && pwrite && aligned && !wr_blocked && !paddr[11]
                      && !paddr[10];
  assign pslverr    = psel && penable && pwrite && wr_blocked;

  // Read decode.
  always @*
  begin
    next_prdata = 32'h00000000;
    if (aligned && (paddr[11:10] == 2'h0))
    begin
      case (reg_idx)
        `PPM_IDX_PORT1_CTRL:   next_prdata = {24'h000000, port1_phy_control};
        `PPM_IDX_PORT2_CTRL:   next_prdata = {24'h000000, port2_phy_control};
        `PPM_IDX_POWER_MODE:   next_prdata = {24'h000000, power_mode_control};
        `PPM_IDX_SLEEP_DELAY:  next_prdata = {24'h000000, sleep_delay_time};
        `PPM_IDX_POWER_STATUS: next_prdata = {29'h00000000, state};
        default:               next_prdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= next_prdata;
  end

  // ****************************************************************
  // Register file.
  // ****************************************************************
  // Registers are never reset by a mode change, so contents survive
  // soft power down and power saving.
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      port1_phy_control  <= `PPM_RST_PORT_CTRL;
      port2_phy_control  <= `PPM_RST_PORT_CTRL;
      power_mode_control <= `PPM_RST_POWER_MODE;
      sleep_delay_time   <= `PPM_RST_SLEEP_DELAY;
    end
    else if (wr_take)
    begin
      case (reg_idx)
        `PPM_IDX_PORT1_CTRL:  port1_phy_control  <= pwdata[7:0];
        `PPM_IDX_PORT2_CTRL:  port2_phy_control  <= pwdata[7:0];
        `PPM_IDX_POWER_MODE:  power_mode_control <= pwdata[7:0];
        `PPM_IDX_SLEEP_DELAY: sleep_delay_time   <= pwdata[7:0];
        default:              power_mode_control <= power_mode_control;
      endcase
    end
  end

  // ****************************************************************
  // Power state machine.
  // ****************************************************************
  // The state follows the stored mode one cycle after the write, so a
  // mode change never acts in the middle of its own bus transfer.
  always @*
  begin
    next_state = state;
    case (mode)
      `PPM_MODE_NORMAL:
        next_state = ST_NORMAL;
      `PPM_MODE_SOFT_PD:
        next_state = ST_SOFT_PD;
      `PPM_MODE_PSAVE:
        // Saving only while negotiating with no cable; any activity
        // or a link attempt brings the PHY back to full power.
        if (autoneg_en && !cable_present && !cable_energy && !link_up)
          next_state = ST_PSAVE;
        else
          next_state = ST_NORMAL;
      `PPM_MODE_ENERGY:
        if (state == ST_ED_LOW)
          next_state = cable_energy ? ST_ED_ON : ST_ED_LOW;
        else if (state != ST_ED_ON)
          next_state = ST_ED_ON;
        else if (!cable_energy && (idle_units > {1'b0, sleep_delay_time}))
          next_state = ST_ED_LOW;
        else
          next_state = ST_ED_ON;
      default:
        next_state = ST_NORMAL;
    endcase
  end

  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= ST_NORMAL;
    else
      state <= next_state;
  end

  // ****************************************************************
  // Go-sleep idle counter.
  // ****************************************************************
  // Counts whole time units without cable energy; it saturates so an
  // idle line never wraps back to a short count.
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      idle_units <= 9'h000;
    else if ((state != ST_ED_ON) || cable_energy)
      idle_units <= 9'h000;
    else if (unit_tick && (idle_units != 9'h1FF))
      idle_units <= idle_units + 9'h001;
  end

  // ****************************************************************
  // Block enables.
  // ****************************************************************
  always @*
  begin
    next_pll_clk_en    = 1'b1;
    next_mac_en        = 1'b1;
    next_host_if_en    = 1'b1;
    next_phy_tx_en     = 2'h3;
    next_phy_rx_en     = 2'h3;
    next_rx_unused_off = 2'h0;
    next_energy_det_en = 1'b0;
    case (state)
      ST_NORMAL:
        next_pll_clk_en = 1'b1;
      ST_PSAVE:
        next_rx_unused_off = 2'h3;
      ST_ED_ON:
        next_energy_det_en = 1'b1;
      ST_ED_LOW:
      begin
        next_pll_clk_en    = 1'b0;
        next_mac_en        = 1'b0;
        next_host_if_en    = 1'b0;
        next_phy_tx_en     = 2'h0;
        next_phy_rx_en     = 2'h0;
        next_energy_det_en = 1'b1;
      end
      ST_SOFT_PD:
      begin
        next_pll_clk_en = 1'b0;
        next_mac_en     = 1'b0;
        next_host_if_en = 1'b0;
        next_phy_tx_en  = 2'h0;
        next_phy_rx_en  = 2'h0;
      end
      default:
        next_pll_clk_en = 1'b1;
    endcase
    // The PLL-disable bit acts in every mode; in normal mode it stops
    // the core clocks too, so software should set it only for sleep.
    if (pll_off)
      next_pll_clk_en = 1'b0;
    // A powered-down port stays off whatever the global mode.
    next_phy_tx_en     = next_phy_tx_en & ~port_pd;
    next_phy_rx_en     = next_phy_rx_en & ~port_pd;
    next_rx_unused_off = next_rx_unused_off & ~port_pd;
  end

  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pll_clk_en        <= 1'b1;
      mac_en            <= 1'b1;
      host_if_en        <= 1'b1;
      phy_tx_en         <= 2'h3;
      phy_rx_en         <= 2'h3;
      phy_rx_unused_off <= 2'h0;
      energy_det_en     <= 1'b0;
    end
    else
    begin
      pll_clk_en        <= next_pll_clk_en;
      mac_en            <= next_mac_en;
      host_if_en        <= next_host_if_en;
      phy_tx_en         <= next_phy_tx_en;
      phy_rx_en         <= next_phy_rx_en;
      phy_rx_unused_off <= next_rx_unused_off;
      energy_det_en     <= next_energy_det_en;
    end
  end

  // ****************************************************************
  // Link pulses and time base.
  // ****************************************************************
  // Pulses run in both energy-detect states while no link is up.
  assign pulse_run = ((state == ST_ED_ON) || (state == ST_ED_LOW)) && !link_up;

  ppm_pulse_timer
  #(
    .PERIOD_CYC (PULSE_PERIOD_CYC),
    .WIDTH_CYC  (`PPM_PULSE_WIDTH_CYC),
    .UNIT_CYC   (SLEEP_UNIT_CYC)
  )
  u_timer
  (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .pulse_run  (pulse_run),
    .link_pulse (link_pulse),
    .unit_tick  (unit_tick)
  );

endmodule // ppm_power_ctrl

/* test/ppm_power_ctrl_asserts.sv */
`timescale 1ns/100ps
`include "ppm_consts.vh"

// ****************************************************************
// Checker on the top ports of the power controller.
// ****************************************************************
module ppm_power_ctrl_asserts
(
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        cable_energy,
  input wire        pll_clk_en,
  input wire        mac_en,
  input wire        host_if_en,
  input wire [1:0]  phy_tx_en,
  input wire [1:0]  phy_rx_en,
  input wire        energy_det_en,
  input wire        link_pulse
);
  localparam [11:0] ad_mode = {2'b00, `PPM_IDX_POWER_MODE, 2'b00};
  localparam [11:0] ad_p1   = {2'b00, `PPM_IDX_PORT1_CTRL, 2'b00};
  reg [5:0] hi_cnt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Length of the current link pulse, judged at the edge where it ends.
  always @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      hi_cnt <= 6'h00;
    else
      hi_cnt <= link_pulse ? hi_cnt + 6'h01 : 6'h00;

  // An accepted write to one address; a refused write has no effect downstream.
  sequence s_wr(a);
    psel && penable && pwrite && paddr == a && !pslverr;
  endsequence

  a_ready_zero: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_err_access: assert property (pslverr |-> psel && penable && pwrite)
    else $error("pslverr outside a write access");
  a_pulse_width: assert property ($fell(link_pulse) |-> hi_cnt == 6'h1E)
    else $error("link pulse width wrong");
  a_pll_off_bit: assert property ((s_wr(ad_mode) ##0 pwdata[2]) |-> ##2 !pll_clk_en)
    else $error("pll still on");
  a_soft_pd_off: assert property ((s_wr(ad_mode) ##0 pwdata[1:0] == 2'h2)
    |-> ##3 (!pll_clk_en && !mac_en && phy_tx_en == 2'h0 && phy_rx_en == 2'h0))
    else $error("soft power down left blocks on");
  a_normal_back: assert property ((s_wr(ad_mode) ##0 pwdata[2:0] == 3'h0)
    |-> ##3 (pll_clk_en && mac_en && host_if_en))
    else $error("normal mode not restored");
  a_port_down: assert property ((s_wr(ad_p1) ##0 pwdata[3])
    |-> ##2 (!phy_tx_en[0] && !phy_rx_en[0]))
    else $error("port 1 phy still on");
  a_wake_energy: assert property (energy_det_en && !mac_en && cable_energy
    |-> ##[1:3] mac_en)
    else $error("no wake on energy");
  a_sleep_refuse: assert property (energy_det_en && !mac_en && !$past(cable_energy)
    && psel && penable && pwrite |-> pslverr)
    else $error("write taken while host interface off");
endmodule // ppm_power_ctrl_asserts

bind ppm_power_ctrl ppm_power_ctrl_asserts u_chk (.ref_clk, .sys_rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .pslverr, .cable_energy, .pll_clk_en, .mac_en,
  .host_if_en, .phy_tx_en, .phy_rx_en, .energy_det_en, .link_pulse);

/* test/ppm_link_partner.sv */
`timescale 1ns/100ps

// ****************************************************************
// Cable and far-end station: energy only while plugged and talking.
// ****************************************************************
module ppm_link_partner
(
  input  wire ref_clk,
  input  wire plug,
  input  wire talk,
  output reg  cable_present = 1'b0,
  output reg  cable_energy  = 1'b0,
  output reg  link_up       = 1'b0
);
  reg [2:0] up_cnt = 3'h0;

  // Link comes up only after energy has been steady for a while, as a real partner needs.
  always @(posedge ref_clk)
  begin
    cable_present <= plug;
    cable_energy  <= plug & talk;
    up_cnt        <= (plug & talk) ? ((up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1) : 3'h0;
    link_up       <= (up_cnt == 3'h7);
  end
endmodule // ppm_link_partner

/* test/phy_power_mode_control_test.sv */
`timescale 1ns/100ps
`include "ppm_consts.vh"

// ****************************************************************
// Register-driven tests of every power mode.
// ****************************************************************
module phy_power_mode_control_test;
  localparam [11:0] ad_p1   = {2'b00, `PPM_IDX_PORT1_CTRL, 2'b00};
  localparam [11:0] ad_p2   = {2'b00, `PPM_IDX_PORT2_CTRL, 2'b00};
  localparam [11:0] ad_mode = {2'b00, `PPM_IDX_POWER_MODE, 2'b00};
  localparam [11:0] ad_slp  = {2'b00, `PPM_IDX_SLEEP_DELAY, 2'b00};
  localparam [11:0] ad_st   = {2'b00, `PPM_IDX_POWER_STATUS, 2'b00};
  reg         ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg         autoneg_en = 1'b0, plug = 1'b0, talk = 1'b0, er;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h00000000, rd;
  wire        pready, pslverr, pll_clk_en, mac_en, host_if_en, energy_det_en, link_pulse;
  wire        cable_present, cable_energy, link_up;
  wire [31:0] prdata;
  wire [1:0]  phy_tx_en, phy_rx_en, phy_rx_unused_off;
  wire [7:0]  en_vec = {pll_clk_en, mac_en, host_if_en, phy_tx_en, phy_rx_en, energy_det_en};
  integer     miscompares = 0, check_count = 0, n;

  // Short pulse period and go-sleep unit keep the run brief.
  ppm_power_ctrl #(.PULSE_PERIOD_CYC(100), .SLEEP_UNIT_CYC(4)) u_dut (.ref_clk, .sys_rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .autoneg_en,
    .cable_present, .cable_energy, .link_up, .pll_clk_en, .mac_en, .host_if_en, .phy_tx_en,
    .phy_rx_en, .phy_rx_unused_off, .energy_det_en, .link_pulse);
  ppm_link_partner u_far (.ref_clk, .plug, .talk, .cable_present, .cable_energy, .link_up);

  // Clock at 250 MHz.
  always #2 ref_clk = ~ref_clk;

  task chk(input [31:0] s, input [31:0] e);
  begin
    check_count = check_count + 1;
    if (s !== e)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH at %0t: seen %h, expected %h", $time, s, e);
    end
  end
  endtask

  // One APB transfer; request is held until pready is seen at a rising edge.
  task apb(input w, input [11:0] a, input [7:0] d);
  begin
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  task wr(input [11:0] a, input [7:0] d, input e);
  begin
    apb(1'b1, a, d);
    chk(er, e);
  end
  endtask

  task rdc(input [11:0] a, input [31:0] e);
  begin
    apb(1'b0, a, 8'h00);
    chk(rd, e);
  end
  endtask

  // Outputs follow a mode write two edges later; one spare edge lets them settle.
  task settle;
    repeat (3) @(posedge ref_clk);
  endtask

  // Waits a bounded time for a level on link_pulse.
  task wait_pulse(input v);
  begin
    n = 0;
    while (link_pulse !== v && n < 300)
    begin
      @(posedge ref_clk);
      n = n + 1;
    end
    if (link_pulse !== v)
      chk(link_pulse, v);
  end
  endtask

  task complete_run;
  begin
    $display("comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask

  // Main sequence.
  initial
  begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc(ad_mode, 32'h00);
    rdc(ad_slp, 32'h50);
    rdc(ad_p1, 32'h00);
    rdc(ad_p2, 32'h00);
    chk(en_vec, 8'hFE);
    wr(12'h004, 8'hFF, 1'b0);
    rdc(12'h004, 32'h00);
    $display("reset test done");
    wr(ad_p1, 8'h08, 1'b0);
    settle;
    chk(en_vec, 8'hF4);
    rdc(ad_p1, 32'h08);
    wr(ad_p2, 8'h08, 1'b0);
    settle;
    chk(en_vec, 8'hE0);
    wr(ad_p1, 8'h00, 1'b0);
    wr(ad_p2, 8'h00, 1'b0);
    wr(ad_mode, 8'h04, 1'b0);
    settle;
    chk(en_vec, 8'h7E);
    rdc(ad_mode, 32'h04);
    $display("port and pll test done");
    wr(ad_mode, 8'h03, 1'b0);
    settle;
    rdc(ad_st, 32'h00);
    autoneg_en <= 1'b1;
    settle;
    rdc(ad_st, 32'h01);
    chk(en_vec[7:3], 5'h1F);
    chk(phy_rx_unused_off, 2'h3);
    rdc(ad_slp, 32'h50);
    plug <= 1'b1;
    settle;
    rdc(ad_st, 32'h00);
    plug <= 1'b0;
    autoneg_en <= 1'b0;
    wr(ad_mode, 8'h00, 1'b0);
    $display("power saving test done");
    wr(ad_slp, 8'h02, 1'b0);
    wr(ad_mode, 8'h02, 1'b0);
    settle;
    chk(en_vec, 8'h00);
    wr(ad_slp, 8'h07, 1'b1);
    rdc(ad_slp, 32'h02);
    rdc(ad_st, 32'h04);
    wr(ad_mode, 8'h00, 1'b0);
    settle;
    chk(en_vec, 8'hFE);
    $display("soft power down test done");
    wr(ad_mode, 8'h01, 1'b0);
    n = 0;
    while (en_vec !== 8'h01 && n < 300)
    begin
      @(posedge ref_clk);
      n = n + 1;
    end
    chk(n >= 8 && n < 40, 1'b1);
    wr(ad_slp, 8'h05, 1'b1);
    rdc(ad_st, 32'h03);
    wait_pulse(1'b0);
    wait_pulse(1'b1);
    wait_pulse(1'b0);
    chk(n, 30);
    wait_pulse(1'b1);
    chk(n + 30, 100);
    plug <= 1'b1;
    talk <= 1'b1;
    n = 0;
    while (mac_en !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      n = n + 1;
    end
    chk(n <= 5, 1'b1);
    rdc(ad_st, 32'h02);
    wr(ad_mode, 8'h00, 1'b0);
    plug <= 1'b0;
    talk <= 1'b0;
    settle;
    chk(en_vec, 8'hFE);
    $display("energy detect test done");
    complete_run;
  end

  // Watchdog well beyond the expected run of about 330 cycles.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares = miscompares + 1;
    complete_run;
  end
endmodule // phy_power_mode_control_test
